// File: inc/hsw_pkg.sv
package hsw_pkg;
    localparam logic [4:0] MCODE_TOP = 5'h01;
    localparam logic [4:0] ADDR_FIXED = 5'h13;
    localparam logic RW_WRITE = 1'b0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int CTRL_LOAD_HI = 5;
    localparam int CTRL_LOAD_LO = 4;
    localparam int CTRL_CHAN_HI = 2;
    localparam int CTRL_CHAN_LO = 1;
    localparam int CTRL_PDSEL = 0;
    localparam int SAMPLE_W = 10;
    localparam int WORD_W = 14;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [3:0] {
        PH_IDLE,
        PH_MCODE,
        PH_ADDR,
        PH_CTRL,
        PH_HIGH,
        PH_LOW,
        PH_PD1,
        PH_PD2,
        PH_IGNORE
    } hsw_phase_e;
endpackage

// File: rtl/hsw_write_path.sv
// Word buffer between the bus receiver and the user side
module hsw_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    logic push;
    logic pop;

    // Honest flags from the fill count
    assign in_ready = (count_r != FULL_CNT);
    assign out_valid = (count_r != '0);
    assign out_data = mem_r[rd_ptr_r];
    assign push = clk_en && in_valid && in_ready;
    assign pop = clk_en && out_valid && out_ready;

    // Storage write, depth assumed a power of two for pointer wrap
    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem_r[wr_ptr_r] <= in_data;
    end

    // Pointers and fill count
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
            if (push && !pop)
                count_r <= count_r + 1'b1;
            else if (pop && !push)
                count_r <= count_r - 1'b1;
        end
    end
endmodule

// Fast-mode write receiver of the two-wire slave
module hsw_write_path (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic addr_pin_hi,
    input wire logic addr_pin_lo,
    output logic hs_mode,
    output logic [1:0] load_mode,
    output logic [1:0] chan_sel,
    output logic power_down_select,
    output logic pwrdn_mode_bit_a,
    output logic pwrdn_mode_bit_b,
    output logic pwrdn_update,
    output logic word_valid,
    input wire logic word_ready,
    output logic [hsw_pkg::WORD_W-1:0] word_data
);
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic [1:0] ahi_sync_r;
    logic [1:0] alo_sync_r;
    logic scl_d_r;
    logic sda_d_r;
    logic scl_rise;
    logic scl_fall;
    logic start_evt;
    logic stop_evt;
    logic byte_evt;
    logic [7:0] shift_r;
    logic [3:0] cnt_r;
    logic ack_slot_r;
    logic ack_nxt;
    logic hs_mode_r;
    hsw_pkg::hsw_phase_e phase_r;
    hsw_pkg::hsw_phase_e phase_nxt;
    logic [7:0] hi_byte_r;
    logic [7:0] pd_first_r;
    logic [7:0] my_addr;
    logic push;
    logic fifo_in_ready;
    logic [hsw_pkg::WORD_W-1:0] push_data;

    // Two-stage synchronisers, then a delay stage for edges
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            ahi_sync_r <= 2'h0;
            alo_sync_r <= 2'h0;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else if (clk_en)
        begin
            scl_sync_r <= {scl_sync_r[0], scl_in};
            sda_sync_r <= {sda_sync_r[0], sda_in};
            ahi_sync_r <= {ahi_sync_r[0], addr_pin_hi};
            alo_sync_r <= {alo_sync_r[0], addr_pin_lo};
            scl_d_r <= scl_sync_r[1];
            sda_d_r <= sda_sync_r[1];
        end
    end

    // Bus events on the sampled lines
    assign scl_rise = clk_en && scl_sync_r[1] && !scl_d_r;
    assign scl_fall = clk_en && !scl_sync_r[1] && scl_d_r;
    assign start_evt = clk_en && scl_sync_r[1] && scl_d_r && !sda_sync_r[1] && sda_d_r;
    assign stop_evt = clk_en && scl_sync_r[1] && scl_d_r && sda_sync_r[1] && !sda_d_r;
    assign byte_evt = scl_fall && !ack_slot_r && (cnt_r == hsw_pkg::BITS_PER_BYTE);
    assign my_addr = {hsw_pkg::ADDR_FIXED, ahi_sync_r[1], alo_sync_r[1], hsw_pkg::RW_WRITE};

    // Word: load mode, channel, ten sample bits
    assign push_data = {load_mode, chan_sel, hi_byte_r, shift_r[7:6]};
    assign push = byte_evt && (phase_r == hsw_pkg::PH_LOW) && fifo_in_ready;

    // Byte decision: acknowledge and next phase
    always_comb
    begin
        ack_nxt = 1'b0;
        phase_nxt = phase_r;
        unique case (phase_r)
            hsw_pkg::PH_IDLE, hsw_pkg::PH_IGNORE:
                phase_nxt = phase_r;
            hsw_pkg::PH_MCODE:
                phase_nxt = hsw_pkg::PH_IGNORE;
            hsw_pkg::PH_ADDR:
            begin
                ack_nxt = (shift_r == my_addr);
                phase_nxt = ack_nxt ? hsw_pkg::PH_CTRL : hsw_pkg::PH_IGNORE;
            end
            hsw_pkg::PH_CTRL:
            begin
                ack_nxt = 1'b1;
                phase_nxt = shift_r[hsw_pkg::CTRL_PDSEL] ? hsw_pkg::PH_PD1 : hsw_pkg::PH_HIGH;
            end
            hsw_pkg::PH_HIGH:
            begin
                ack_nxt = 1'b1;
                phase_nxt = hsw_pkg::PH_LOW;
            end
            hsw_pkg::PH_LOW:
            begin
                ack_nxt = fifo_in_ready;
                phase_nxt = fifo_in_ready ? hsw_pkg::PH_HIGH : hsw_pkg::PH_IGNORE;
            end
            hsw_pkg::PH_PD1:
            begin
                ack_nxt = 1'b1;
                phase_nxt = hsw_pkg::PH_PD2;
            end
            hsw_pkg::PH_PD2:
            begin
                ack_nxt = 1'b1;
                phase_nxt = hsw_pkg::PH_IGNORE;
            end
            default:
                phase_nxt = hsw_pkg::PH_IGNORE;
        endcase
    end

    // Bit shifter and acknowledge slot
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            shift_r <= 8'h00;
            cnt_r <= 4'h0;
            ack_slot_r <= 1'b0;
            sda_oe_n <= 1'b1;
        end
        else if (start_evt || stop_evt)
        begin
            cnt_r <= 4'h0;
            ack_slot_r <= 1'b0;
            sda_oe_n <= 1'b1;
        end
        else if (byte_evt)
        begin
            ack_slot_r <= 1'b1;
            sda_oe_n <= !ack_nxt;
        end
        else if (scl_fall && ack_slot_r)
        begin
            ack_slot_r <= 1'b0;
            cnt_r <= 4'h0;
            sda_oe_n <= 1'b1;
        end
        else if (scl_rise && !ack_slot_r && cnt_r != hsw_pkg::BITS_PER_BYTE)
        begin
            shift_r <= {shift_r[6:0], sda_sync_r[1]};
            cnt_r <= cnt_r + 4'h1;
        end
    end

    // Transfer phase and fast-mode flag
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            phase_r <= hsw_pkg::PH_IDLE;
            hs_mode_r <= 1'b0;
        end
        else if (stop_evt)
        begin
            phase_r <= hsw_pkg::PH_IDLE;
            hs_mode_r <= 1'b0;
        end
        else if (start_evt)
            phase_r <= hs_mode_r ? hsw_pkg::PH_ADDR : hsw_pkg::PH_MCODE;
        else if (byte_evt)
        begin
            phase_r <= phase_nxt;
            if (phase_r == hsw_pkg::PH_MCODE && shift_r[7:3] == hsw_pkg::MCODE_TOP)
                hs_mode_r <= 1'b1;
        end
    end

    // Control byte fields and held bytes
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            load_mode <= 2'h0;
            chan_sel <= 2'h0;
            power_down_select <= 1'b0;
            hi_byte_r <= 8'h00;
            pd_first_r <= 8'h00;
            pwrdn_mode_bit_a <= 1'b0;
            pwrdn_mode_bit_b <= 1'b0;
            pwrdn_update <= 1'b0;
        end
        else if (clk_en)
        begin
            pwrdn_update <= 1'b0;
            if (byte_evt && phase_r == hsw_pkg::PH_CTRL)
            begin
                load_mode <= shift_r[hsw_pkg::CTRL_LOAD_HI:hsw_pkg::CTRL_LOAD_LO];
                chan_sel <= shift_r[hsw_pkg::CTRL_CHAN_HI:hsw_pkg::CTRL_CHAN_LO];
                power_down_select <= shift_r[hsw_pkg::CTRL_PDSEL];
            end
            if (byte_evt && phase_r == hsw_pkg::PH_HIGH)
                hi_byte_r <= shift_r;
            if (byte_evt && phase_r == hsw_pkg::PH_PD1)
                pd_first_r <= shift_r;
            if (byte_evt && phase_r == hsw_pkg::PH_PD2)
            begin
                pwrdn_mode_bit_a <= pd_first_r[7];
                pwrdn_mode_bit_b <= pd_first_r[6];
                pwrdn_update <= 1'b1;
            end
        end
    end

    assign sda_out = 1'b0;
    assign hs_mode = hs_mode_r;

    hsw_fifo #(
        .WIDTH(hsw_pkg::WORD_W),
        .DEPTH(hsw_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(push_data),
        .out_valid(word_valid),
        .out_ready(word_ready),
        .out_data(word_data)
    );

    // Checks on the receiver
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    a_mcode_no_ack: assert property (byte_evt && phase_r == hsw_pkg::PH_MCODE |=> sda_oe_n)
        else $error("master code was acknowledged");
    a_addr_match_ack: assert property (byte_evt && phase_r == hsw_pkg::PH_ADDR
        && shift_r == my_addr |=> !sda_oe_n && phase_r == hsw_pkg::PH_CTRL)
        else $error("matching address not acknowledged");
    a_addr_miss_quiet: assert property (byte_evt && phase_r == hsw_pkg::PH_ADDR
        && shift_r != my_addr |=> sda_oe_n && phase_r == hsw_pkg::PH_IGNORE)
        else $error("foreign address acknowledged");
    a_ctrl_decode: assert property (byte_evt && phase_r == hsw_pkg::PH_CTRL |=> !sda_oe_n
        && power_down_select == $past(shift_r[0])
        && phase_r == ($past(shift_r[0]) ? hsw_pkg::PH_PD1 : hsw_pkg::PH_HIGH))
        else $error("control byte misdecoded");
    a_high_then_low: assert property (byte_evt && phase_r == hsw_pkg::PH_HIGH
        |=> !sda_oe_n && phase_r == hsw_pkg::PH_LOW && hi_byte_r == $past(shift_r))
        else $error("high byte mishandled");
    a_low_word: assert property (push |-> push_data[1:0] == shift_r[7:6]
        && push_data[9:2] == hi_byte_r
        ##1 u_fifo.mem_r[$past(u_fifo.wr_ptr_r)] == $past(push_data))
        else $error("sample word assembled wrong");
    a_low_full_nack: assert property (byte_evt && phase_r == hsw_pkg::PH_LOW && !fifo_in_ready
        |=> sda_oe_n)
        else $error("low byte acknowledged while buffer full");
    a_pd_two_bytes: assert property (byte_evt && phase_r == hsw_pkg::PH_PD1
        |=> phase_r == hsw_pkg::PH_PD2)
        else $error("power-down sequence broken");
    a_pd_update: assert property (byte_evt && phase_r == hsw_pkg::PH_PD2 |=> pwrdn_update
        && phase_r == hsw_pkg::PH_IGNORE ##1 !pwrdn_update)
        else $error("power-down update not one pulse");
    a_stop_exit: assert property (stop_evt |=> !hs_mode && phase_r == hsw_pkg::PH_IDLE
        && sda_oe_n)
        else $error("stop did not leave fast mode");
    a_drive_in_slot: assert property (!sda_oe_n |-> ack_slot_r)
        else $error("data line driven outside acknowledge");

    c_hs_entered: cover property (!hs_mode ##1 hs_mode);
    c_word_pushed: cover property (push);
    c_pd_done: cover property (pwrdn_update);
    c_full_nack: cover property (byte_evt && phase_r == hsw_pkg::PH_LOW && !fifo_in_ready);
endmodule

// File: tb/hsw_bus_master.sv
// Bus master model: drives the clock and the open-drain data line
module hsw_bus_master (
    input wire logic clk_sys,
    input wire logic sda_line,
    output logic scl,
    output logic sda_drv
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle with both lines released; clock stands still between frames
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // Wait n falling edges of the system clock
    task automatic hc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Start or repeated start, after any acknowledge has been released
    task automatic start_cond();
        hc(4);
        sda_drv = 1'b1;
        hc(2);
        scl = 1'b1;
        hc(4);
        sda_drv = 1'b0;
        hc(4);
        scl = 1'b0;
    endtask

    // Stop condition, leaves both lines high
    task automatic stop_cond();
        hc(2);
        sda_drv = 1'b0;
        hc(2);
        scl = 1'b1;
        hc(4);
        sda_drv = 1'b1;
        hc(4);
    endtask

    // One byte msb first, data moving only while the clock is low
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            hc(2);
            sda_drv = b[i];
            hc(2);
            scl = 1'b1;
            hc(4);
            scl = 1'b0;
        end
        hc(2);
        sda_drv = 1'b1;
        hc(2);
        scl = 1'b1;
        hc(3);
        ack = ~sda_line;
        hc(1);
        scl = 1'b0;
    endtask
endmodule

// File: tb/test_hs_mode_i2c_write_path.sv
// Bench for the fast-mode write receiver
module test_hs_mode_i2c_write_path;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic addr_pin_hi = 1'b1;
    logic addr_pin_lo = 1'b0;
    logic word_ready = 1'b0;
    logic scl, sda_drv, sda_out, sda_oe_n, hs_mode, power_down_select, word_valid;
    logic pwrdn_mode_bit_a, pwrdn_mode_bit_b, pwrdn_update;
    logic [1:0] load_mode, chan_sel;
    logic [hsw_pkg::WORD_W-1:0] word_data;
    int err_total = 0;
    int checked = 0;
    int upd_cnt = 0;
    // Wired-AND data line with pull-up
    wire logic sda_line = sda_drv & (sda_oe_n | sda_out);

    hsw_bus_master u_hsw_bus_master (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl),
        .sda_drv(sda_drv));

    hsw_write_path u_hsw_write_path (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(1'b1),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .addr_pin_hi(addr_pin_hi), .addr_pin_lo(addr_pin_lo), .hs_mode(hs_mode),
        .load_mode(load_mode), .chan_sel(chan_sel), .power_down_select(power_down_select),
        .pwrdn_mode_bit_a(pwrdn_mode_bit_a), .pwrdn_mode_bit_b(pwrdn_mode_bit_b),
        .pwrdn_update(pwrdn_update), .word_valid(word_valid), .word_ready(word_ready),
        .word_data(word_data));

    // System clock, 20 ns
    initial
    begin
        forever #10 clk_sys = ~clk_sys;
    end

    // Count power-down update pulses, sampled where settled
    always @(negedge clk_sys)
    begin
        if (pwrdn_update === 1'b1)
            upd_cnt++;
    end

    // Compare and report
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic end_sim();
        if (err_total == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Sample value of word i
    function automatic logic [9:0] smp(input int i);
        return 10'(i * 93 + 17);
    endfunction

    // Send a byte and judge the acknowledge
    task automatic xfer(input logic [7:0] b, input logic exp_ack);
        logic ack;
        u_hsw_bus_master.put_byte(b, ack);
        chk(16'(ack), 16'(exp_ack));
    endtask

    // Master code, repeated start, address
    task automatic open_hs(input logic [7:0] addr, input logic exp_ack);
        u_hsw_bus_master.start_cond();
        xfer(8'h0D, 1'b0);
        u_hsw_bus_master.start_cond();
        chk(16'(hs_mode), 16'h0001);
        xfer(addr, exp_ack);
    endtask

    // Values held in reset
    task automatic t_reset();
        chk(16'({sda_oe_n, hs_mode, word_valid, pwrdn_update}), 16'h0008);
    endtask

    // Nine pairs into a stalled buffer, readdress, then drain
    task automatic t_stream();
        logic [9:0] s;
        open_hs(8'h9C, 1'b1);
        xfer(8'h26, 1'b1);
        chk(16'({load_mode, chan_sel, power_down_select}), 16'h0016);
        for (int i = 0; i < 9; i++)
        begin
            s = smp(i);
            xfer(s[9:2], 1'b1);
            xfer({s[1:0], 6'h2A}, 1'(i < 8));
        end
        chk(16'(word_valid), 16'h0001);
        u_hsw_bus_master.start_cond();
        xfer(8'h9C, 1'b1);
        xfer(8'h26, 1'b1);
        u_hsw_bus_master.stop_cond();
        u_hsw_bus_master.hc(8);
        chk(16'(hs_mode), 16'h0000);
        for (int i = 0; i < 8; i++)
        begin
            for (int k = 0; k < 20 && word_valid !== 1'b1; k++)
                @(negedge clk_sys);
            // Bound used up: count it and close the run
            if (word_valid !== 1'b1)
            begin
                err_total++;
                end_sim();
            end
            chk(16'(word_valid), 16'h0001);
            chk(16'(word_data), 16'({2'h2, 2'h3, smp(i)}));
            word_ready = 1'b1;
            @(negedge clk_sys);
            word_ready = 1'b0;
        end
        u_hsw_bus_master.hc(2);
        chk(16'(word_valid), 16'h0000);
    endtask

    // Wrong pins, read direction, bad master code
    task automatic t_badaddr();
        open_hs(8'h98, 1'b0);
        u_hsw_bus_master.stop_cond();
        open_hs(8'h9D, 1'b0);
        u_hsw_bus_master.stop_cond();
        u_hsw_bus_master.start_cond();
        xfer(8'h1A, 1'b0);
        u_hsw_bus_master.start_cond();
        chk(16'(hs_mode), 16'h0000);
        u_hsw_bus_master.stop_cond();
    endtask

    // Power-down path with other pin straps
    task automatic t_pwrdn();
        addr_pin_hi = 1'b0;
        addr_pin_lo = 1'b1;
        open_hs(8'h9A, 1'b1);
        xfer(8'h13, 1'b1);
        chk(16'({load_mode, chan_sel, power_down_select}), 16'h000B);
        xfer(8'h80, 1'b1);
        xfer(8'h3F, 1'b1);
        chk(16'({pwrdn_mode_bit_a, pwrdn_mode_bit_b}), 16'h0002);
        chk(16'(upd_cnt), 16'h0001);
        xfer(8'h00, 1'b0);
        u_hsw_bus_master.stop_cond();
    endtask

    // Hang guard
    initial
    begin
        #400000;
        err_total++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        repeat (3) @(negedge clk_sys);
        t_reset();
        sys_rst = 1'b0;
        u_hsw_bus_master.hc(4);
        t_stream();
        t_badaddr();
        t_pwrdn();
        end_sim();
    end
endmodule
